// ===== core/drc_checker.sv
// Descriptor reserved-field checker with an Avalon-MM register slave.

// Operation
// - Flag bit 6 is reserved for every operation; set means reject.
// - Flag bits 23:16 are reserved unless the operation defines their use.
// - Flags in the allowance list are accepted, subject to conditional reservations.
// - Create delta record allows all ten listed flags; bytes 38-39, 52-55, 57-63 zero.
// - DIF check allows only block-on-fault, address-1 selector, fence; listed bytes zero.
// - DIF insert allows all but check-result and address-3 selector; listed bytes zero.
// - DIF strip allows the DIF insert flags; bytes 38-39, 41, 43-47, 56-63 zero.
// - CRC generation allows block-on-fault, address-1/3 selectors, fence; listed bytes zero.
// - Completion interrupt request reserved when user interrupts off, PASID on, not privileged.
// - Completion interrupt handle must be zero when no completion interrupt is requested.
// - Fence is reserved for descriptors placed directly on a work queue.
// - Block-on-fault is reserved when the work queue disables it.
// - Destination readback is reserved without readback capability.
// - Steering tag selectors reserved when tag mode is zero; record selector also without record.
// - Drain address-1/2 selectors reserved when their readback address is invalid.
// - Without valid record address: address, record request and record selector reserved.
// - Cache control reserved when the matching cache-control capability is zero.
// - Drain readback-valid bits reserved without drain readback capability.
// - A drain must request a completion record or a completion interrupt.
// - Comparing, create delta, CRC and DIF check need record address valid and record request.
// - Flag failures report 0x11; other nonzero reserved fields report 0x12.
// - Flag failures expose offending flags in the invalid-flags register.
module drc_checker #(
   parameter int DESC_WORDS = 16
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             check_done,
   output logic             check_pass,
   output logic      [7:0]  check_cause,
   output logic      [23:0] invalid_flags,
   output logic             exec_start
);

   // ==========================================================
   // Elaboration checks
   if (DESC_WORDS != drc_pkg::DESC_WORDS) begin : g_bad_words
      $error("Descriptor must be sixteen 32-bit words.");
   end

   // ==========================================================
   // Storage
   logic [31:0]             desc_q [DESC_WORDS];
   wire  [DESC_WORDS*32-1:0] desc_flat;
   drc_pkg::drc_cfg_type    cfg_q;
   drc_pkg::drc_state_type  state_q;
   drc_pkg::drc_state_type  state_d;
   logic                    wait_q;
   logic [31:0]             rdata_q;
   logic                    done_q;
   logic                    pass_q;
   logic [7:0]              cause_q;
   logic [23:0]             inval_q;
   logic                    exec_q;
   logic                    sticky_done_q;

   // ==========================================================
   // Bus decode
   // The slave answers one cycle after a request appears, so waitrequest
   // is a plain flop and the register file never sees a combinational path.
   wire        req        = avs_read | avs_write;
   wire        accept     = req & wait_q;
   wire        wr_accept  = accept & avs_write;
   wire        rd_accept  = accept & avs_read;
   wire [7:0]  word_addr  = {avs_address[7:2], 2'b00};
   wire        sel_desc   = (avs_address[7:6] == 2'b00);
   wire        sel_cfg    = (word_addr == drc_pkg::OFF_CONFIG);
   wire        sel_ctrl   = (word_addr == drc_pkg::OFF_CONTROL);
   wire        sel_status = (word_addr == drc_pkg::OFF_STATUS);
   wire        sel_inval  = (word_addr == drc_pkg::OFF_INVALID);
   wire        idle       = (state_q == drc_pkg::ST_IDLE);
   wire        eval       = (state_q == drc_pkg::ST_EVAL);
   wire        start_hit  = wr_accept & sel_ctrl & avs_byteenable[0]
                            & avs_writedata[drc_pkg::CTRL_START] & idle;
   wire [31:0] status_w   = {16'h0000, cause_q, 6'h00, pass_q, sticky_done_q};
   wire [31:0] cfg_w      = 32'(cfg_q);
   wire [31:0] rd_word    = sel_desc   ? desc_q[avs_address[5:2]] :
                            sel_cfg    ? cfg_w :
                            sel_status ? status_w :
                            sel_inval  ? {8'h00, inval_q} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (reset) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~accept;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (rd_accept) begin
         rdata_q <= rd_word;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_q <= '0;
      end else if (wr_accept & sel_cfg) begin
         cfg_q <= drc_pkg::CFG_WIDTH'(drc_pkg::merge_lanes(cfg_w, avs_writedata,
                                                           avs_byteenable));
      end
   end

   // Descriptor words are frozen during evaluation so the verdict always
   // belongs to one consistent descriptor image.
   for (genvar w = 0; w < DESC_WORDS; w++) begin : g_desc
      wire wr_w = wr_accept & sel_desc & idle & (avs_address[5:2] == 4'(w));
      always_ff @(posedge clk) begin
         if (reset) begin
            desc_q[w] <= 32'h0000_0000;
         end else if (wr_w) begin
            desc_q[w] <= drc_pkg::merge_lanes(desc_q[w], avs_writedata, avs_byteenable);
         end
      end
      assign desc_flat[w*32 +: 32] = desc_q[w];
   end

   // ==========================================================
   // Descriptor fields
   wire [23:0] fl      = desc_q[drc_pkg::WORD_FLAGS][23:0];
   wire [7:0]  opcode  = desc_q[drc_pkg::WORD_FLAGS][31:24];
   wire        priv    = desc_q[drc_pkg::WORD_PRIV][drc_pkg::BIT_PRIV];
   wire [63:0] cra     = {desc_q[drc_pkg::WORD_CRA_HI], desc_q[drc_pkg::WORD_CRA_LO]};
   wire [15:0] handle  = desc_q[drc_pkg::WORD_HANDLE][15:0];
   wire        crav    = fl[drc_pkg::FL_CRAV];
   wire        req_cr  = fl[drc_pkg::FL_REQ_CR];
   wire        req_ci  = fl[drc_pkg::FL_REQ_CI];
   wire        is_drain = (opcode == drc_pkg::OP_DRAIN);
   wire        is_flush = (opcode == drc_pkg::OP_FLUSH);
   wire        tag_off  = (cfg_q.tag_hint_mode_select == 3'h0);

   drc_pkg::drc_profile_type prof;
   assign prof = drc_pkg::op_profile(opcode);

   wire        al_bof    = prof.allowed[9];
   wire        al_check  = prof.allowed[8];
   wire        al_cache  = prof.allowed[7];
   wire        al_strict = prof.allowed[6];
   wire        al_rdback = prof.allowed[5];
   wire        al_dst_st = prof.allowed[4];
   wire        al_a1     = prof.allowed[3];
   wire        al_a2     = prof.allowed[2];
   wire        al_a3     = prof.allowed[1];
   wire        al_fence  = prof.allowed[0];

   // ==========================================================
   // Flag checks
   wire [23:0] bad;
   wire drain_none = is_drain & ~req_cr & ~req_ci;
   wire cr_missing = prof.need_cr & ~(crav & req_cr);
   wire cc_cap     = is_flush ? cfg_q.cc_flush : cfg_q.cc_mem;
   wire ci_rsvd    = ~cfg_q.umi_en & cfg_q.wq_pasid_en & ~priv;

   assign bad[drc_pkg::FL_FENCE]    = fl[drc_pkg::FL_FENCE] & (~al_fence | ~cfg_q.in_batch);
   assign bad[drc_pkg::FL_BOF]      = fl[drc_pkg::FL_BOF] & (~al_bof | ~cfg_q.wq_bof_en);
   assign bad[drc_pkg::FL_CRAV]     = prof.need_cr & ~crav;
   assign bad[drc_pkg::FL_REQ_CR]   = (req_cr & ~crav) | (cr_missing & ~req_cr)
                                      | drain_none;
   assign bad[drc_pkg::FL_REQ_CI]   = (req_ci & ci_rsvd) | drain_none;
   assign bad[drc_pkg::FL_CHECK]    = fl[drc_pkg::FL_CHECK] & ~al_check;
   assign bad[drc_pkg::FL_RSVD]     = fl[drc_pkg::FL_RSVD];
   assign bad[drc_pkg::FL_STRICT]   = fl[drc_pkg::FL_STRICT] & ~al_strict;
   assign bad[drc_pkg::FL_CACHE]    = fl[drc_pkg::FL_CACHE] & (~al_cache | ~cc_cap);
   assign bad[drc_pkg::FL_A1_TC]    = fl[drc_pkg::FL_A1_TC]
                                      & (~al_a1 | (is_drain & ~fl[drc_pkg::FL_RB1_VAL]));
   assign bad[drc_pkg::FL_A2_TC]    = fl[drc_pkg::FL_A2_TC]
                                      & (~al_a2 | (is_drain & ~fl[drc_pkg::FL_RB2_VAL]));
   assign bad[drc_pkg::FL_A3_TC]    = fl[drc_pkg::FL_A3_TC] & ~al_a3;
   assign bad[drc_pkg::FL_CR_TC]    = fl[drc_pkg::FL_CR_TC] & ~crav;
   assign bad[drc_pkg::FL_CR_ST]    = fl[drc_pkg::FL_CR_ST] & (~crav | tag_off);
   assign bad[drc_pkg::FL_READBACK] = fl[drc_pkg::FL_READBACK]
                                      & (~al_rdback | ~cfg_q.readback_support);
   assign bad[drc_pkg::FL_DEST_ST]  = fl[drc_pkg::FL_DEST_ST] & (~al_dst_st | tag_off);
   // Only drain gives meaning to the operation-specific bits here.
   assign bad[drc_pkg::FL_RB1_VAL]  = fl[drc_pkg::FL_RB1_VAL]
                                      & (~is_drain | ~cfg_q.drain_rb_support);
   assign bad[drc_pkg::FL_RB2_VAL]  = fl[drc_pkg::FL_RB2_VAL]
                                      & (~is_drain | ~cfg_q.drain_rb_support);
   assign bad[23:18]                = fl[23:18];

   wire flag_hit = |bad;

   // ==========================================================
   // Reserved field checks
   wire [63:0] byte_nz;
   for (genvar b = 0; b < 64; b++) begin : g_bytes
      assign byte_nz[b] = |desc_flat[b*8 +: 8];
   end

   wire bytes_hit  = |(byte_nz & prof.rsvd_bytes);
   wire cra_hit    = ~crav & (|cra);
   wire handle_hit = ~req_ci & (|handle);
   wire rsvd_hit   = bytes_hit | cra_hit | handle_hit;

   // Flag failures take precedence so the invalid-flags field is always filled
   // when any flag is wrong.
   wire [7:0] cause_d = flag_hit ? drc_pkg::CODE_FLAGS :
                        rsvd_hit ? drc_pkg::CODE_RSVD : drc_pkg::CODE_OK;
   wire       pass_d  = ~flag_hit & ~rsvd_hit;

   // ==========================================================
   // Sequencer
   always_comb begin
      case (state_q)
         drc_pkg::ST_IDLE: state_d = start_hit ? drc_pkg::ST_EVAL : drc_pkg::ST_IDLE;
         drc_pkg::ST_EVAL: state_d = drc_pkg::ST_IDLE;
         default:          state_d = drc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= drc_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // One verdict per evaluation; execution is released only on a pass.
   always_ff @(posedge clk) begin
      if (reset) begin
         done_q  <= 1'b0;
         exec_q  <= 1'b0;
         pass_q  <= 1'b0;
         cause_q <= 8'h00;
         inval_q <= 24'h00_0000;
      end else begin
         done_q <= eval;
         exec_q <= eval & pass_d;
         if (eval) begin
            pass_q  <= pass_d;
            cause_q <= cause_d;
            inval_q <= bad;
         end
      end
   end

   // The done bit is set by an evaluation and cleared by the next start;
   // the two cannot meet because starts are only taken while idle.
   always_ff @(posedge clk) begin
      if (reset) begin
         sticky_done_q <= 1'b0;
      end else if (eval) begin
         sticky_done_q <= 1'b1;
      end else if (start_hit) begin
         sticky_done_q <= 1'b0;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign check_done      = done_q;
   assign check_pass      = pass_q;
   assign check_cause     = cause_q;
   assign invalid_flags   = inval_q;
   assign exec_start      = exec_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   AST_BIT6_REJECT: assert property (
      eval && fl[drc_pkg::FL_RSVD] |=> check_done && !check_pass
         && check_cause == drc_pkg::CODE_FLAGS && invalid_flags[drc_pkg::FL_RSVD])
      else $error("Reserved flag bit 6 was not rejected.");

   AST_OPSPEC_BITS: assert property (
      eval |=> invalid_flags[23:18] == $past(fl[23:18]))
      else $error("Operation-specific high flags not reported.");

   AST_FENCE_DIRECT: assert property (
      eval && fl[drc_pkg::FL_FENCE] && !cfg_q.in_batch |=> !check_pass && !exec_start)
      else $error("Fence accepted on a directly queued descriptor.");

   AST_BOF_DISABLED: assert property (
      eval && fl[drc_pkg::FL_BOF] && !cfg_q.wq_bof_en |=> invalid_flags[drc_pkg::FL_BOF])
      else $error("Block-on-fault accepted while disabled.");

   AST_DRAIN_NEEDS_REQ: assert property (
      eval && is_drain && !req_cr && !req_ci |=> check_cause == drc_pkg::CODE_FLAGS)
      else $error("Drain without completion request accepted.");

   AST_RSVD_CODE: assert property (
      eval && !flag_hit && rsvd_hit |=> check_cause == drc_pkg::CODE_RSVD
         && invalid_flags == 24'h00_0000)
      else $error("Reserved field fault not reported as 0x12.");

   AST_HANDLE_ZERO: assert property (
      eval && !req_ci && handle != 16'h0000 |=> !check_pass)
      else $error("Nonzero handle accepted without interrupt request.");

   AST_EXEC_AFTER_PASS: assert property (
      start_hit |=> eval ##1 (check_done && (exec_start == check_pass)))
      else $error("Execution release does not follow the verdict.");

   AST_DONE_PULSE: assert property (
      check_done |=> !check_done)
      else $error("Done stayed high for more than one cycle.");

endmodule

// ===== core/drc_pkg.sv
// Shared constants, types and decode tables for the descriptor reserved-field checker.
package drc_pkg;

   // ==========================================================
   // Register map and layout
   localparam int         DESC_WORDS   = 16;
   localparam int         CFG_WIDTH    = 11;
   localparam logic [7:0] OFF_CONFIG   = 8'h40;
   localparam logic [7:0] OFF_CONTROL  = 8'h44;
   localparam logic [7:0] OFF_STATUS   = 8'h48;
   localparam logic [7:0] OFF_INVALID  = 8'h4c;
   localparam int         CTRL_START   = 0;
   localparam int         WORD_PRIV    = 0;
   localparam int         BIT_PRIV     = 31;
   localparam int         WORD_FLAGS   = 1;
   localparam int         WORD_CRA_LO  = 2;
   localparam int         WORD_CRA_HI  = 3;
   localparam int         WORD_HANDLE  = 9;

   // ==========================================================
   // Flag bit positions inside the 24-bit flags field
   localparam int FL_FENCE    = 0;
   localparam int FL_BOF      = 1;
   localparam int FL_CRAV     = 2;
   localparam int FL_REQ_CR   = 3;
   localparam int FL_REQ_CI   = 4;
   localparam int FL_CHECK    = 5;
   localparam int FL_RSVD     = 6;
   localparam int FL_STRICT   = 7;
   localparam int FL_CACHE    = 8;
   localparam int FL_A1_TC    = 9;
   localparam int FL_A2_TC    = 10;
   localparam int FL_A3_TC    = 11;
   localparam int FL_CR_TC    = 12;
   localparam int FL_CR_ST    = 13;
   localparam int FL_READBACK = 14;
   localparam int FL_DEST_ST  = 15;
   localparam int FL_RB1_VAL  = 16;
   localparam int FL_RB2_VAL  = 17;

   // ==========================================================
   // Status codes and operation codes
   localparam logic [7:0] CODE_OK    = 8'h01;
   localparam logic [7:0] CODE_FLAGS = 8'h11;
   localparam logic [7:0] CODE_RSVD  = 8'h12;
   localparam logic [7:0] OP_NOOP    = 8'h00;
   localparam logic [7:0] OP_BATCH   = 8'h01;
   localparam logic [7:0] OP_DRAIN   = 8'h02;
   localparam logic [7:0] OP_MOVE    = 8'h03;
   localparam logic [7:0] OP_FILL    = 8'h04;
   localparam logic [7:0] OP_CMP     = 8'h05;
   localparam logic [7:0] OP_CMP_PAT = 8'h06;
   localparam logic [7:0] OP_CR_DLT  = 8'h07;
   localparam logic [7:0] OP_AP_DLT  = 8'h08;
   localparam logic [7:0] OP_DUALC   = 8'h09;
   localparam logic [7:0] OP_CRC     = 8'h10;
   localparam logic [7:0] OP_CP_CRC  = 8'h11;
   localparam logic [7:0] OP_DIF_CHK = 8'h12;
   localparam logic [7:0] OP_DIF_INS = 8'h13;
   localparam logic [7:0] OP_DIF_STR = 8'h14;
   localparam logic [7:0] OP_DIF_UPD = 8'h15;
   localparam logic [7:0] OP_FLUSH   = 8'h20;

   // ==========================================================
   // Types
   typedef struct packed {
      logic       in_batch;
      logic       drain_rb_support;
      logic       cc_flush;
      logic       cc_mem;
      logic [2:0] tag_hint_mode_select;
      logic       readback_support;
      logic       wq_bof_en;
      logic       wq_pasid_en;
      logic       umi_en;
   } drc_cfg_type;

   // Allowed order: bof, check, cache, strict, readback, dest tag, a1, a2, a3, fence.
   typedef struct packed {
      logic [9:0]  allowed;
      logic [63:0] rsvd_bytes;
      logic        need_cr;
   } drc_profile_type;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EVAL = 1'b1
   } drc_state_type;

   // ==========================================================
   // Helper functions
   function automatic logic [63:0] byte_range(input int lo, input int hi);
      logic [63:0] m;
      m = '0;
      for (int i = lo; i <= hi; i++) begin
         m[i] = 1'b1;
      end
      return m;
   endfunction

   function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  be);
      logic [31:0] m;
      m = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic drc_profile_type op_profile(input logic [7:0] op);
      drc_profile_type p;
      p.need_cr = 1'b0;
      case (op)
         OP_NOOP: begin
            p.allowed = 10'h001;
            p.rsvd_bytes = byte_range(16, 35) | byte_range(38, 63);
         end
         OP_DRAIN: begin
            p.allowed = 10'h00c;
            p.rsvd_bytes = byte_range(32, 35) | byte_range(38, 63);
         end
         OP_MOVE: begin
            p.allowed = 10'h2fd;
            p.rsvd_bytes = byte_range(38, 63);
         end
         OP_FILL, OP_FLUSH: begin
            p.allowed = 10'h2f5;
            p.rsvd_bytes = (op == OP_FILL) ? byte_range(38, 63)
                                           : byte_range(16, 23) | byte_range(38, 63);
         end
         OP_CMP, OP_CMP_PAT: begin
            p.allowed = (op == OP_CMP) ? 10'h30d : 10'h309;
            p.rsvd_bytes = byte_range(38, 39) | byte_range(41, 63);
            p.need_cr = 1'b1;
         end
         OP_CR_DLT: begin
            p.allowed = 10'h3ff;
            p.rsvd_bytes = byte_range(38, 39) | byte_range(52, 55) | byte_range(57, 63);
            p.need_cr = 1'b1;
         end
         OP_AP_DLT, OP_CP_CRC: begin
            p.allowed = (op == OP_AP_DLT) ? 10'h2fd : 10'h2ff;
            p.rsvd_bytes = byte_range(38, 39) | byte_range(44, 63);
            p.need_cr = (op == OP_CP_CRC);
         end
         OP_DUALC: begin
            p.allowed = 10'h2ff;
            p.rsvd_bytes = byte_range(38, 39) | byte_range(48, 63);
         end
         OP_CRC: begin
            p.allowed = 10'h20b;
            p.rsvd_bytes = byte_range(24, 31) | byte_range(38, 39) | byte_range(44, 63);
            p.need_cr = 1'b1;
         end
         OP_DIF_CHK: begin
            p.allowed = 10'h209;
            p.rsvd_bytes = byte_range(24, 31) | byte_range(38, 39) | byte_range(41, 41)
                           | byte_range(43, 47) | byte_range(56, 63);
            p.need_cr = 1'b1;
         end
         OP_DIF_INS: begin
            p.allowed = 10'h2fd;
            p.rsvd_bytes = byte_range(38, 40) | byte_range(43, 55);
         end
         OP_DIF_STR: begin
            p.allowed = 10'h2fd;
            p.rsvd_bytes = byte_range(38, 39) | byte_range(41, 41) | byte_range(43, 47)
                           | byte_range(56, 63);
         end
         OP_DIF_UPD: begin
            p.allowed = 10'h2fd;
            p.rsvd_bytes = byte_range(38, 39) | byte_range(43, 47);
         end
         OP_BATCH: begin
            p.allowed = 10'h008;
            p.rsvd_bytes = byte_range(24, 31) | byte_range(38, 63);
         end
         default: begin
            p.allowed = 10'h3ff;
            p.rsvd_bytes = '0;
         end
      endcase
      return p;
   endfunction

endpackage

// ===== sim/drc_host.sv
// Host model that submits descriptors and configuration over Avalon-MM.
module drc_host (
   input  wire logic        clk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic      [7:0]  avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic      [31:0] avs_writedata
);
   timeunit 1ns;
   timeprecision 1ns;
   int tmo = 0;
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
   end
   // ==========================================================
   // Bus transfer
   // Waitrequest is sampled at each rising edge; the request stands until it is seen low or 20 edges pass.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) tmo++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
endmodule

// ===== sim/descriptor_reserved_field_checker_test.sv
// Self-checking bench for the descriptor reserved-field checker.
module descriptor_reserved_field_checker_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        check_done;
   logic        check_pass;
   logic [7:0]  check_cause;
   logic [23:0] invalid_flags;
   logic        exec_start;
   logic [31:0] q;
   int          n_mismatch = 0;
   int          checks_done = 0;
   drc_checker i_dut (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .check_done, .check_pass,
      .check_cause, .invalid_flags, .exec_start);
   drc_host i_host (.clk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read,
      .avs_write, .avs_writedata);
   initial begin
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // Checks
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // An expected flag set of all ones means the offending bits are not compared.
   task automatic run(input logic [7:0] op, input logic [23:0] fl, input logic [10:0] cfg,
      input int w, input logic [31:0] v, input logic [7:0] cs, input logic [23:0] inv);
      int n;
      for (int i = 0; i < 16; i++) begin
         i_host.xfer(1'b1, 8'(i * 4), (i == 1) ? {op, fl} : ((i == w) ? v : '0), q);
      end
      i_host.xfer(1'b1, 8'h40, 32'(cfg), q);
      i_host.xfer(1'b1, 8'h44, 32'h0000_0001, q);
      if (i_host.tmo != 0) final_report();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (check_done !== 1'b1 && n < 10);
      chk("done", 32'(check_done), 32'h0000_0001);
      if (check_done !== 1'b1) final_report();
      chk("cause", 32'(check_cause), 32'(cs));
      chk("pass", 32'(check_pass), 32'(cs == 8'h01));
      chk("exec", 32'(exec_start), 32'(cs == 8'h01));
      if (inv !== 24'hff_ffff) chk("flags", 32'(invalid_flags), 32'(inv));
   endtask
   task automatic final_report;
      n_mismatch += i_host.tmo;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // Sequence
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      run(8'h03, 24'h0c, 11'h000, 0, '0, 8'h01, 24'h0);
      run(8'h03, 24'h40, 11'h000, 0, '0, 8'h11, 24'h40);
      run(8'h03, 24'h1_0000, 11'h000, 0, '0, 8'h11, 24'h1_0000);
      run(8'h00, 24'h01, 11'h400, 0, '0, 8'h01, 24'h0);
      run(8'h00, 24'h01, 11'h000, 0, '0, 8'h11, 24'h01);
      run(8'h01, 24'h80, 11'h000, 0, '0, 8'h11, 24'h80);
      run(8'h10, 24'h0c, 11'h000, 6, 1, 8'h12, 24'hff_ffff);
      run(8'h10, 24'h10c, 11'h080, 0, '0, 8'h11, 24'h100);
      run(8'h10, 24'h00, 11'h000, 0, '0, 8'h11, 24'h0c);
      run(8'h02, 24'h00, 11'h000, 0, '0, 8'h11, 24'h18);
      run(8'h02, 24'h10, 11'h001, 0, '0, 8'h01, 24'h0);
      run(8'h02, 24'h1_0010, 11'h001, 0, '0, 8'h11, 24'h1_0000);
      run(8'h02, 24'h210, 11'h201, 0, '0, 8'h11, 24'h200);
      run(8'h03, 24'h10, 11'h002, 0, '0, 8'h11, 24'h10);
      run(8'h03, 24'h10, 11'h002, 0, 32'h8000_0000, 8'h01, 24'h0);
      run(8'h03, 24'h00, 11'h000, 9, 1, 8'h12, 24'hff_ffff);
      run(8'h03, 24'h02, 11'h000, 0, '0, 8'h11, 24'h02);
      run(8'h03, 24'h02, 11'h004, 0, '0, 8'h01, 24'h0);
      run(8'h03, 24'h4000, 11'h000, 0, '0, 8'h11, 24'h4000);
      run(8'h03, 24'h8000, 11'h000, 0, '0, 8'h11, 24'h8000);
      run(8'h03, 24'h2000, 11'h010, 0, '0, 8'h11, 24'h2000);
      run(8'h03, 24'h00, 11'h000, 2, 1, 8'h12, 24'hff_ffff);
      run(8'h20, 24'h100, 11'h080, 0, '0, 8'h11, 24'h100);
      run(8'h20, 24'h100, 11'h100, 0, '0, 8'h01, 24'h0);
      run(8'h12, 24'h0c, 11'h000, 10, 32'h0000_ff00, 8'h12, 24'hff_ffff);
      run(8'h13, 24'h20, 11'h000, 0, '0, 8'h11, 24'h20);
      run(8'h14, 24'h00, 11'h000, 10, 32'h0000_ff00, 8'h12, 24'hff_ffff);
      run(8'h07, 24'h80c, 11'h000, 14, 32'h0000_0100, 8'h12, 24'hff_ffff);
      run(8'h08, 24'h800, 11'h000, 0, '0, 8'h11, 24'h800);
      i_host.xfer(1'b0, 8'h4c, '0, q);
      chk("invalid_reg", q, 32'h0000_0800);
      run(8'h11, 24'h80c, 11'h000, 0, '0, 8'h01, 24'h0);
      i_host.xfer(1'b0, 8'h48, '0, q);
      chk("status_reg", q, 32'h0000_0103);
      i_host.xfer(1'b0, 8'h80, '0, q);
      chk("unmapped", q, 32'h0000_0000);
      final_report();
   end
endmodule
